//--- common/sgs_pkg.sv
package sgs_pkg;
  localparam int unsigned NUM_GROUPS = 8;
  localparam int unsigned ADDR_W = 4;
  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_ACTIVE = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_FORCE_SEL = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_FORCE_EN = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_USED = 4'hc;
  localparam logic [ADDR_W-1:0] OFF_REMOTE = 4'h0;
  localparam logic [3:0] GRP_NONE = 4'h0;
  localparam logic [3:0] GRP_ONE = 4'h1;
  localparam logic [2:0] USED_RESET = 3'h0;
  localparam logic [3:0] SEL_RESET = 4'h0;
  localparam logic [31:0] BUS_ZERO = 32'h0000_0000;

  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [ADDR_W-1:0] adr;
    logic [31:0] dat;
  } sgs_wb_req_t;

  typedef struct packed {
    logic not_configured;
    logic lower_priority;
    logic force_fail;
  } sgs_fail_t;
endpackage

//--- core/sgs_regfile.sv
`timescale 1ns/1ns
module sgs_regfile (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire sgs_pkg::sgs_wb_req_t req_i,
  input wire logic [3:0] active_i,
  input wire sgs_pkg::sgs_fail_t fail_i,
  output logic ack_o,
  output logic err_o,
  output logic [31:0] dat_o,
  output logic [3:0] force_sel_o,
  output logic force_en_o,
  output logic [2:0] used_o,
  output logic [3:0] remote_o,
  output logic remote_wr_o
);
  logic hit;
  logic known;
  logic wr;
  assign hit = req_i.cyc && req_i.stb && !ack_o && !err_o;
  always_comb begin
    known = 1'b1;
    unique case (req_i.adr)
      sgs_pkg::OFF_ACTIVE, sgs_pkg::OFF_FORCE_SEL, sgs_pkg::OFF_FORCE_EN,
      sgs_pkg::OFF_USED: known = 1'b1;
      default: known = 1'b0;
    endcase
  end
  assign wr = hit && known && req_i.we && req_i.sel[0];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
    end else begin
      ack_o <= hit && known;
      err_o <= hit && !known;
    end
  end

  // Writable settings; remote request is written to bits 3:0 of the active word and read back in bits 7:4
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      force_sel_o <= sgs_pkg::SEL_RESET;
      force_en_o <= 1'b0;
      used_o <= sgs_pkg::USED_RESET;
      remote_o <= sgs_pkg::SEL_RESET;
      remote_wr_o <= 1'b0;
    end else begin
      remote_wr_o <= 1'b0;
      if (wr) begin
        unique case (req_i.adr)
          sgs_pkg::OFF_FORCE_SEL: force_sel_o <= req_i.dat[3:0];
          sgs_pkg::OFF_FORCE_EN: force_en_o <= req_i.dat[0];
          sgs_pkg::OFF_USED: used_o <= req_i.dat[2:0];
          default: begin
            remote_o <= req_i.dat[3:0];
            remote_wr_o <= 1'b1;
          end
        endcase
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      dat_o <= sgs_pkg::BUS_ZERO;
    end else if (hit && known && !req_i.we) begin
      unique case (req_i.adr)
        sgs_pkg::OFF_FORCE_SEL: dat_o <= {28'h000_0000, force_sel_o};
        sgs_pkg::OFF_FORCE_EN: dat_o <= {31'h0000_0000, force_en_o};
        sgs_pkg::OFF_USED: dat_o <= {29'h0000_0000, used_o};
        default: dat_o <= {21'h00_0000, fail_i, remote_o, active_i};
      endcase
    end
  end
endmodule

//--- core/sgs_selector.sv
// The Wishbone slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ns
// Summary of operation
// R1 - Group one highest, eight lowest priority
// R2 - Static group one blocks all others
// R3 - Static group blocks lower groups
// R4 - Static group eight blocks nothing
// R5 - Request inputs accept pulse or level
// R6 - Forced select: zero none, 1-8 groups
// R7 - Force enable overrides automatic control
// R8 - Force only when enabled and group used
// R9 - Forced group stays after force ends
// R10 - Static requests retake control after force
// R11 - Used-groups field enables groups 1..n+1
// R12 - Newly enabled group loads defaults
// R13 - Remote change refused under higher hold
// R14 - Active group readable, one after reset
// R15 - Pulse-activated group stays until replaced
// R16 - Up to eight groups, one by default
// R17 - Flags for unconfigured and outranked requests
// R18 - Active group updates next clock edge
module sgs_selector (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic wb_err_o,
  output logic [31:0] wb_dat_o,
  input wire logic [7:0] group_request_i,
  output logic [3:0] active_group_o,
  output logic [7:0] group_enabled_o,
  output logic [7:0] load_defaults_o,
  output logic fail_not_configured_o,
  output logic fail_lower_priority_o,
  output logic fail_force_o
);
  sgs_pkg::sgs_wb_req_t req;
  sgs_pkg::sgs_fail_t fail;
  logic [3:0] force_sel;
  logic force_en;
  logic [2:0] used;
  logic [3:0] remote;
  logic remote_wr;
  logic [7:0] req_q;
  logic [7:0] rise;
  logic [7:0] held;
  logic [7:0] enabled;
  logic [7:0] blocked;
  logic force_en_q;
  logic force_wr;
  logic [3:0] force_sel_q;
  logic [3:0] next_active;
  logic next_nc;
  logic next_lp;
  logic next_ff;
  logic [3:0] active;

  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, sel: wb_sel_i,
                 adr: wb_adr_i, dat: wb_dat_i};
  assign fail = '{not_configured: fail_not_configured_o,
                  lower_priority: fail_lower_priority_o, force_fail: fail_force_o};

  sgs_regfile u_regs (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .req_i(req),
    .active_i(active),
    .fail_i(fail),
    .ack_o(wb_ack_o),
    .err_o(wb_err_o),
    .dat_o(wb_dat_o),
    .force_sel_o(force_sel),
    .force_en_o(force_en),
    .used_o(used),
    .remote_o(remote),
    .remote_wr_o(remote_wr)
  );

  // Per-group enable, edge and static-hold terms
  genvar g;
  generate
    for (g = 0; g < 8; g++) begin : gen_grp
      assign enabled[g] = (g <= int'(used)); // R11 R16
      assign rise[g] = group_request_i[g] && !req_q[g]; // R5
      assign held[g] = group_request_i[g] && req_q[g];
      // A group is blocked when any used higher group holds a static level
      if (g == 0) begin : gen_top
        assign blocked[g] = 1'b0; // R1
      end else begin : gen_low
        assign blocked[g] = |(held[g-1:0] & enabled[g-1:0]); // R2 R3 R4
      end
    end
  endgenerate

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_q <= 8'h00;
      force_en_q <= 1'b0;
      force_sel_q <= sgs_pkg::SEL_RESET;
    end else begin
      req_q <= group_request_i;
      force_en_q <= force_en;
      force_sel_q <= force_sel;
    end
  end

  // A new forced value or a fresh enable counts as one forced pulse
  assign force_wr = force_en && (!force_en_q || force_sel != force_sel_q); // R9

  always_comb begin
    next_active = active;
    next_nc = 1'b0;
    next_lp = 1'b0;
    next_ff = 1'b0;
    if (force_en) begin // R7
      if (force_wr && force_sel != sgs_pkg::GRP_NONE) begin // R6
        // Codes above eight name no group and are refused like an unused group
        if (force_sel <= 4'(sgs_pkg::NUM_GROUPS) && enabled[force_sel[2:0] - 3'h1]) begin
          next_active = force_sel; // R8
        end else begin
          next_ff = 1'b1; // R8 R17
        end
      end
    end else begin
      // Static levels retake selection the cycle force is released
      for (int i = 7; i >= 0; i--) begin
        if ((rise[i] || held[i] || (!force_en && force_en_q && group_request_i[i]))
            && !blocked[i]) begin
          if (enabled[i]) begin
            next_active = 4'(i + 1); // R1 R10 R15
          end else if (rise[i]) begin
            next_nc = 1'b1; // R17
          end
        end else if (rise[i] && blocked[i]) begin
          next_lp = 1'b1; // R17
        end
      end
      if (remote_wr && remote != sgs_pkg::GRP_NONE) begin
        if (remote > 4'(sgs_pkg::NUM_GROUPS) || !enabled[remote[2:0] - 3'h1]) begin // R13
          next_nc = 1'b1; // R17
        end else if (blocked[remote[2:0] - 3'h1] || held[remote[2:0] - 3'h1] == 1'b0
                     && |(held & enabled & ((8'h01 << (remote[2:0] - 3'h1)) - 8'h01))) begin
          next_lp = 1'b1; // R13
        end else if (!(|(rise | held))) begin
          next_active = remote;
        end
      end
    end
    // Active group must always be a used group
    if (!enabled[next_active[2:0] - 3'h1]) begin
      next_active = sgs_pkg::GRP_ONE; // R16
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      active <= sgs_pkg::GRP_ONE; // R14
      active_group_o <= sgs_pkg::GRP_ONE;
      group_enabled_o <= 8'h01;
      load_defaults_o <= 8'h00;
      fail_not_configured_o <= 1'b0;
      fail_lower_priority_o <= 1'b0;
      fail_force_o <= 1'b0;
    end else begin
      active <= next_active; // R18
      active_group_o <= next_active; // R14
      group_enabled_o <= enabled;
      load_defaults_o <= enabled & ~group_enabled_o; // R12
      fail_not_configured_o <= next_nc;
      fail_lower_priority_o <= next_lp;
      fail_force_o <= next_ff;
    end
  end

  a_reset_group: assert property (@(posedge clk_i) // R14
    $fell(rst_i) |-> active_group_o == sgs_pkg::GRP_ONE)
    else $error("active group not one after reset");
  a_top_static: assert property (@(posedge clk_i) disable iff (rst_i) // R2
    group_request_i[0] && req_q[0] && !force_en |=> active_group_o == sgs_pkg::GRP_ONE)
    else $error("static group one lost");
  // Compared with the registered mask, which moves on the same edge as the output
  a_enabled_only: assert property (@(posedge clk_i) disable iff (rst_i) // R16
    group_enabled_o[active_group_o[2:0] - 3'h1])
    else $error("active group not enabled");
  // A shrinking used field may legally drop the active group to one
  a_pulse_hold: assert property (@(posedge clk_i) disable iff (rst_i) // R15
    !force_en && !remote_wr && $stable(used) && !(|(group_request_i | req_q))
    |=> $stable(active_group_o))
    else $error("active group changed without request");
  a_pulse_take: assert property (@(posedge clk_i) disable iff (rst_i) // R18
    !force_en && rise[2] && enabled[2] && !(|group_request_i[1:0])
    |=> active_group_o == 4'h3)
    else $error("pulse request not taken next edge");
  a_eight_open: assert property (@(posedge clk_i) disable iff (rst_i) // R4
    !force_en && held[7] && rise[3] && enabled[3] && !(|group_request_i[2:0])
    |=> active_group_o == 4'h4)
    else $error("static group eight blocked a request");
  a_force_take: assert property (@(posedge clk_i) disable iff (rst_i) // R8
    force_wr && force_sel != sgs_pkg::GRP_NONE && force_sel <= 4'(sgs_pkg::NUM_GROUPS)
    && enabled[force_sel[2:0] - 3'h1] |=> active_group_o == $past(force_sel))
    else $error("forced group not taken");
  a_force_fail: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    force_wr && force_sel != sgs_pkg::GRP_NONE && !enabled[force_sel[2:0] - 3'h1]
    |=> fail_force_o && $stable(active_group_o))
    else $error("forced unused group not flagged");
  a_force_override: assert property (@(posedge clk_i) disable iff (rst_i) // R7
    force_en && !force_wr |=> $stable(active_group_o) || $past(used, 2) != used)
    else $error("automatic control under force");
  a_force_release: assert property (@(posedge clk_i) disable iff (rst_i) // R10
    !force_en && force_en_q && held[3] && enabled[3] && !(|group_request_i[2:0])
    |=> active_group_o == 4'h4)
    else $error("static request not retaken after force");
  a_new_defaults: assert property (@(posedge clk_i) disable iff (rst_i) // R12
    $rose(group_enabled_o[1]) |-> load_defaults_o[1])
    else $error("defaults not loaded");
  a_static_block: assert property (@(posedge clk_i) disable iff (rst_i) // R3
    !force_en && held[4] && enabled[4] && |rise[7:5] |=> fail_lower_priority_o)
    else $error("blocked request not flagged");
  a_not_conf: assert property (@(posedge clk_i) disable iff (rst_i) // R17
    !force_en && rise[4] && !enabled[4] && !blocked[4] |=> fail_not_configured_o)
    else $error("unused group request not flagged");
  a_remote_refuse: assert property (@(posedge clk_i) disable iff (rst_i) // R13
    !force_en && remote_wr && remote == 4'h2 && enabled[1] && held[0]
    |=> fail_lower_priority_o && active_group_o == sgs_pkg::GRP_ONE)
    else $error("remote change taken under higher hold");

  c_force: cover property (@(posedge clk_i) force_wr ##1 fail_force_o == 1'b0);
  c_pulse: cover property (@(posedge clk_i) rise[3] && enabled[3]);
  c_remote: cover property (@(posedge clk_i) remote_wr ##1 fail_lower_priority_o);
  c_release: cover property (@(posedge clk_i) $fell(force_en) && |group_request_i);
endmodule

//--- testbench/sgs_far_end.sv
`timescale 1ns/1ns
module sgs_far_end (
  input wire logic [7:0] static_i,
  input wire logic [7:0] pulse_i,
  output logic [7:0] req_o
);
  // Each line is a held level or a one-cycle pulse
  assign req_o = static_i | pulse_i;
endmodule

//--- testbench/tb.sv
`timescale 1ns/1ns
module tb;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [31:0] wdat = 32'h0000_0000;
  logic [7:0] stat = 8'h00;
  logic [7:0] puls = 8'h00;
  logic ack, err, fnc, flp, ffc, e;
  logic [31:0] rdat, r;
  logic [7:0] req, en, ld, lds;
  logic [3:0] act, act1;
  logic [2:0] sn;
  int errors = 0;
  int n_checks = 0;
  int ticks = 0;

  sgs_far_end far (.static_i(stat), .pulse_i(puls), .req_o(req));
  sgs_selector uut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_sel_i(4'hf), .wb_adr_i(adr), .wb_dat_i(wdat), .wb_ack_o(ack),
    .wb_err_o(err), .wb_dat_o(rdat), .group_request_i(req), .active_group_o(act),
    .group_enabled_o(en), .load_defaults_o(ld), .fail_not_configured_o(fnc),
    .fail_lower_priority_o(flp), .fail_force_o(ffc));

  initial begin
    forever #4 clk_i = ~clk_i;
  end

  task automatic print_verdict();
    if (errors == 0 && n_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge clk_i) begin
    ticks++;
    if (ticks == 5000) begin
      errors++;
      print_verdict();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do @(posedge clk_i); while (!(ack === 1'b1 || err === 1'b1));
    r = rdat;
    e = err;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask

  // Collects one-cycle flags and load pulses over n edges
  task automatic run(input int n);
    sn = 3'h0;
    lds = 8'h00;
    for (int k = 0; k < n; k++) begin
      @(posedge clk_i);
      // Active group as it stood right after the stimulus edge
      if (k == 0) begin
        act1 = act;
      end
      sn = sn | {fnc, flp, ffc};
      lds = lds | ld;
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    run(3);
  endtask

  task automatic pulse(input logic [7:0] m);
    @(posedge clk_i);
    puls <= m;
    @(posedge clk_i);
    puls <= 8'h00;
    run(3);
  endtask

  task automatic t_reset();
    chk(act, 4'h1);
    chk(en, 8'h01);
    bus(1'b0, sgs_pkg::OFF_ACTIVE, 32'h0000_0000);
    chk(r[3:0], 4'h1);
    bus(1'b0, 4'h2, 32'h0000_0000);
    chk(e, 1'b1);
  endtask

  task automatic t_used();
    wr(sgs_pkg::OFF_USED, 32'h0000_0007);
    chk(lds, 8'hfe);
    chk(en, 8'hff);
    bus(1'b0, sgs_pkg::OFF_USED, 32'h0000_0000);
    chk(r[2:0], 3'h7);
  endtask

  task automatic t_pulse();
    pulse(8'h04);
    chk(act, 4'h3);
    run(6);
    chk(act, 4'h3);
    pulse(8'h50);
    chk(act, 4'h5);
  endtask

  task automatic t_static();
    stat <= 8'h10;
    run(4);
    pulse(8'h40);
    chk(act, 4'h5);
    chk(sn[1], 1'b1);
    pulse(8'h02);
    chk(act1, 4'h2);
    chk(act, 4'h5);
    stat <= 8'h80;
    run(4);
    pulse(8'h08);
    chk(act1, 4'h4);
    chk(act, 4'h8);
    stat <= 8'h01;
    run(4);
    pulse(8'h02);
    chk(act1, 4'h1);
    chk(act, 4'h1);
    chk(sn[1], 1'b1);
    stat <= 8'h00;
    run(2);
  endtask

  task automatic t_force();
    wr(sgs_pkg::OFF_FORCE_SEL, 32'h0000_0006);
    wr(sgs_pkg::OFF_FORCE_EN, 32'h0000_0001);
    chk(act, 4'h6);
    pulse(8'h04);
    chk(act, 4'h6);
    wr(sgs_pkg::OFF_FORCE_EN, 32'h0000_0000);
    chk(act, 4'h6);
    wr(sgs_pkg::OFF_FORCE_EN, 32'h0000_0001);
    stat <= 8'h08;
    run(4);
    chk(act, 4'h6);
    wr(sgs_pkg::OFF_FORCE_EN, 32'h0000_0000);
    chk(act, 4'h4);
    stat <= 8'h00;
    run(2);
  endtask

  task automatic t_fail();
    wr(sgs_pkg::OFF_USED, 32'h0000_0001);
    chk(en, 8'h03);
    chk(act, 4'h1);
    wr(sgs_pkg::OFF_FORCE_SEL, 32'h0000_0005);
    wr(sgs_pkg::OFF_FORCE_EN, 32'h0000_0001);
    chk(sn[0], 1'b1);
    chk(act, 4'h1);
    wr(sgs_pkg::OFF_FORCE_EN, 32'h0000_0000);
    pulse(8'h10);
    chk(sn[2], 1'b1);
  endtask

  task automatic t_remote();
    wr(sgs_pkg::OFF_REMOTE, 32'h0000_0002);
    chk(act, 4'h2);
    stat <= 8'h01;
    run(4);
    wr(sgs_pkg::OFF_REMOTE, 32'h0000_0002);
    chk(act, 4'h1);
    chk(sn[1], 1'b1);
    stat <= 8'h00;
  endtask

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    t_reset();
    t_used();
    t_pulse();
    t_static();
    t_force();
    t_fail();
    t_remote();
    print_verdict();
  end
endmodule
